// ==== grcb_pkg.sv ====
// grcb_pkg: register map, field positions and carrier types of the global request control bank
// assumes an 8-bit register port with a 16-bit address from the serial control front end
package grcb_pkg;
  localparam logic [15:0] GRCB_OFS_SOFT_RESET = 16'h0000;
  localparam logic [15:0] GRCB_OFS_REQUEST_MODE = 16'h0001;
  localparam logic [15:0] GRCB_OFS_TRIGGER = 16'h0002;
  localparam logic [7:0] GRCB_RST_SOFT_RESET = 8'h00;
  localparam logic [7:0] GRCB_RST_REQUEST_MODE = 8'h00;
  localparam logic [7:0] GRCB_RST_TRIGGER = 8'h00;
  localparam logic [7:0] GRCB_MASK_SOFT_RESET = 8'h01;
  localparam logic [7:0] GRCB_MASK_REQUEST_MODE = 8'hDF;
  localparam logic [7:0] GRCB_MASK_TRIGGER = 8'h06;
  localparam int GRCB_BIT_SOFT_RESET = 0;
  localparam int GRCB_BIT_RESEED = 7;
  localparam int GRCB_BIT_HIGH_PERF = 6;
  localparam int GRCB_BIT_HOLDOVER = 4;
  localparam int GRCB_BIT_MUTE = 3;
  localparam int GRCB_BIT_PULSE = 2;
  localparam int GRCB_BIT_RESTART = 1;
  localparam int GRCB_BIT_SLEEP = 0;
  localparam int GRCB_BIT_AUTOTUNE = 2;
  localparam int GRCB_BIT_SLIP = 1;
  localparam logic [3:0] GRCB_SEQ_DONE = 4'h2;
  // holdover latency in loop state-machine clock cycles
  localparam int GRCB_HOLD_LAT_DEB = 6;
  localparam int GRCB_HOLD_LAT_BYP = 2;
  localparam logic [7:0] GRCB_ZERO = 8'h00;

  typedef struct packed {
    logic reseed;
    logic pulse;
    logic slip;
    logic autotune;
  } grcb_events_t;

  typedef struct packed {
    logic high_perf;
    logic mute;
    logic sleep;
    logic holdover;
    logic restart;
    logic soft_reset;
  } grcb_levels_t;
endpackage : grcb_pkg

// ==== grcb_bank.sv ====
// grcb_bank: global soft reset, request/mode and trigger registers with edge detect,
// gated reseed and a holdover request carried into the loop state-machine clock enable
// assumes the loop state-machine rate arrives as a one-cycle enable on clock_i
// Operation
// R1 - soft reset returns every register, divider and state machine to default; here rdata and the pin synchroniser keep their values.
// R2 - reseed acts on its rising edge only, a held level starts nothing more.
// R3 - reseed is taken only while the resync sequencer is in its done state 0010.
// R4 - an accepted reseed reseeds the dividers that listen to sync events.
// R5 - the distribution select bit picks power priority at 0 and noise priority at 1.
// R6 - force holdover drives the reference loop into holdover, debounced into its domain.
// R7 - holdover latency is six loop cycles debounced and two bypassed.
// R8 - software clears the phase detector up and down enables to tristate the charge pump.
// R9 - mute silences every driver while the dividers keep running.
// R10 - the pulse request makes a pulse stream on channels set up for it.
// R11 - restart resets dividers and state machines and keeps configuration.
// R12 - sleep disables both loops, the output network and the buffers.
// R13 - the autotune trigger starts a new oscillator autotune of the synthesis loop.
// R14 - the slip request issues slip events to the channels set up for them.
// R15 - channels react on the slip rising edge and raise the phase sync alarm after.
// R16 - software writes each request bit back to zero before a new request.
`timescale 1ns/10ps
`default_nettype none
module grcb_bank
  import grcb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [3:0] resync_sequencer_state_i,
  input wire logic general_input_pin_i,
  input wire logic loop_tick_i,
  input wire logic debounce_bypass_i,
  output logic reseed_pulse_o,
  output logic pulse_request_o,
  output logic slip_pulse_o,
  output logic autotune_pulse_o,
  output logic reference_loop_holdover_o,
  output logic high_perf_path_o,
  output logic mute_drivers_o,
  output logic sleep_o,
  output logic restart_o,
  output logic soft_reset_o
);
  logic [7:0] soft_reset_reg, next_soft_reset_reg;
  logic [7:0] request_mode_reg, next_request_mode_reg;
  logic [7:0] trigger_reg, next_trigger_reg;
  logic [7:0] rdata, next_rdata;
  grcb_events_t prev_lvl, next_prev_lvl;
  grcb_events_t ev, next_ev;
  grcb_levels_t lvl;
  logic [2:0] pin_sync, next_pin_sync;
  logic pin_level, next_pin_level;
  logic hold_req;
  // one sample fewer than the latency: the output flop is the last stage
  logic [GRCB_HOLD_LAT_DEB-2:0] hold_shift, next_hold_shift;
  logic hold_out, next_hold_out;

  // soft reset is self-clearing: it wipes the three mapped registers, not rdata, the cycle after it is written
  always_comb
  begin
    next_soft_reset_reg = soft_reset_reg;
    next_request_mode_reg = request_mode_reg;
    next_trigger_reg = trigger_reg;
    next_rdata = rdata;
    if (soft_reset_reg[GRCB_BIT_SOFT_RESET])
    begin
      next_soft_reset_reg = GRCB_RST_SOFT_RESET; // R1
      next_request_mode_reg = GRCB_RST_REQUEST_MODE; // R1
      next_trigger_reg = GRCB_RST_TRIGGER; // R1
    end
    else if (wr_en_i)
    begin
      unique case (addr_i)
        GRCB_OFS_SOFT_RESET: next_soft_reset_reg = wdata_i & GRCB_MASK_SOFT_RESET;
        GRCB_OFS_REQUEST_MODE: next_request_mode_reg = wdata_i & GRCB_MASK_REQUEST_MODE;
        GRCB_OFS_TRIGGER: next_trigger_reg = wdata_i & GRCB_MASK_TRIGGER;
        default: next_rdata = rdata;
      endcase
    end
    if (rd_en_i)
    begin
      unique case (addr_i)
        GRCB_OFS_SOFT_RESET: next_rdata = soft_reset_reg;
        GRCB_OFS_REQUEST_MODE: next_rdata = request_mode_reg;
        GRCB_OFS_TRIGGER: next_rdata = trigger_reg;
        default: next_rdata = GRCB_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      soft_reset_reg <= GRCB_RST_SOFT_RESET;
      request_mode_reg <= GRCB_RST_REQUEST_MODE;
      trigger_reg <= GRCB_RST_TRIGGER;
      rdata <= GRCB_ZERO;
    end
    else
    begin
      soft_reset_reg <= next_soft_reset_reg;
      request_mode_reg <= next_request_mode_reg;
      trigger_reg <= next_trigger_reg;
      rdata <= next_rdata;
    end
  end

  // edge detection; a held level never re-fires, so software must return bits to zero
  always_comb
  begin
    next_prev_lvl.reseed = request_mode_reg[GRCB_BIT_RESEED];
    next_prev_lvl.pulse = request_mode_reg[GRCB_BIT_PULSE];
    next_prev_lvl.slip = trigger_reg[GRCB_BIT_SLIP];
    next_prev_lvl.autotune = trigger_reg[GRCB_BIT_AUTOTUNE];
    // a reseed edge outside the done state is dropped, not deferred
    next_ev.reseed = next_prev_lvl.reseed && !prev_lvl.reseed
      && (resync_sequencer_state_i == GRCB_SEQ_DONE); // R2 R3 R4
    next_ev.pulse = next_prev_lvl.pulse && !prev_lvl.pulse; // R10
    next_ev.slip = next_prev_lvl.slip && !prev_lvl.slip; // R14 R15
    next_ev.autotune = next_prev_lvl.autotune && !prev_lvl.autotune; // R13
    // soft reset blocks any new pulse while it is active; one already registered in ev still goes out
    if (soft_reset_reg[GRCB_BIT_SOFT_RESET])
    begin
      next_ev = '0; // R1
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prev_lvl <= '0;
      ev <= '0;
    end
    else
    begin
      prev_lvl <= next_prev_lvl;
      ev <= next_ev;
    end
  end

  // pin passes three flops; the first is read only by the second
  always_comb
  begin
    next_pin_sync = {pin_sync[1:0], general_input_pin_i};
    // a lone disagreeing sample keeps the last agreed level, so glitches vanish
    next_pin_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
    end
    else
    begin
      pin_sync <= next_pin_sync;
      pin_level <= next_pin_level;
    end
  end

  // change counts once second and third stages agree
  assign hold_req = request_mode_reg[GRCB_BIT_HOLDOVER]
    || next_pin_level; // R6

  // shift on each loop tick; debounced output needs a full window of agreeing samples
  always_comb
  begin
    next_hold_shift = hold_shift;
    next_hold_out = hold_out;
    if (soft_reset_reg[GRCB_BIT_SOFT_RESET])
    begin
      next_hold_shift = '0; // R1
      next_hold_out = 1'b0; // R1
    end
    else if (loop_tick_i)
    begin
      next_hold_shift = {hold_shift[GRCB_HOLD_LAT_DEB-3:0], hold_req};
      if (debounce_bypass_i)
      begin
        next_hold_out = hold_shift[GRCB_HOLD_LAT_BYP-2]; // R7
      end
      else if (&hold_shift)
      begin
        next_hold_out = 1'b1; // R6 R7
      end
      else if (~|hold_shift)
      begin
        next_hold_out = 1'b0; // R6 R7
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_shift <= '0;
      hold_out <= 1'b0;
    end
    else
    begin
      hold_shift <= next_hold_shift;
      hold_out <= next_hold_out;
    end
  end

  assign lvl.high_perf = request_mode_reg[GRCB_BIT_HIGH_PERF]; // R5
  assign lvl.mute = request_mode_reg[GRCB_BIT_MUTE]; // R9
  assign lvl.sleep = request_mode_reg[GRCB_BIT_SLEEP]; // R12
  assign lvl.holdover = hold_out;
  // restart clears dividers and sequencers downstream but no register here
  assign lvl.restart = request_mode_reg[GRCB_BIT_RESTART]; // R11
  assign lvl.soft_reset = soft_reset_reg[GRCB_BIT_SOFT_RESET]; // R1

  assign rdata_o = rdata;
  assign reseed_pulse_o = ev.reseed;
  assign pulse_request_o = ev.pulse;
  assign slip_pulse_o = ev.slip;
  assign autotune_pulse_o = ev.autotune;
  assign reference_loop_holdover_o = lvl.holdover;
  assign high_perf_path_o = lvl.high_perf;
  assign mute_drivers_o = lvl.mute;
  assign sleep_o = lvl.sleep;
  assign restart_o = lvl.restart;
  assign soft_reset_o = lvl.soft_reset;
endmodule : grcb_bank
`default_nettype wire

// ==== grcb_chk_sva.sv ====
// grcb_chk_sva: port checks of the request control bank
// bound to grcb_bank, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module grcb_chk_sva
  import grcb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [3:0] resync_sequencer_state_i,
  input wire logic reseed_pulse_o,
  input wire logic pulse_request_o,
  input wire logic slip_pulse_o,
  input wire logic autotune_pulse_o,
  input wire logic mute_drivers_o,
  input wire logic sleep_o,
  input wire logic soft_reset_o
);
  wire logic w1 = wr_en_i && addr_i == GRCB_OFS_REQUEST_MODE;
  wire logic w2 = wr_en_i && addr_i == GRCB_OFS_TRIGGER;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_clr; soft_reset_o ##1 !soft_reset_o && !mute_drivers_o && !sleep_o; endsequence
  // a soft reset written while one is in progress is lost
  property p_soft; wr_en_i && addr_i == GRCB_OFS_SOFT_RESET && !soft_reset_o
    && wdata_i[GRCB_BIT_SOFT_RESET] |=> s_clr; endproperty
  a_soft: assert property (p_soft) else $error("soft reset left state");
  // writes in the soft reset cycle are lost, so they are excluded
  property p_mute; w1 && !soft_reset_o
    |=> mute_drivers_o == $past(wdata_i[GRCB_BIT_MUTE]); endproperty
  a_mute: assert property (p_mute) else $error("mute level wrong");
  property p_sleep; w1 && !soft_reset_o
    |=> sleep_o == $past(wdata_i[GRCB_BIT_SLEEP]); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep level wrong");
  property p_rsd; reseed_pulse_o |-> $past(resync_sequencer_state_i) == GRCB_SEQ_DONE
    && $past(w1 && wdata_i[GRCB_BIT_RESEED], 2); endproperty
  a_rsd: assert property (p_rsd) else $error("reseed without cause");
  property p_once; reseed_pulse_o |=> !reseed_pulse_o; endproperty
  a_once: assert property (p_once) else $error("reseed repeated");
  property p_pls; pulse_request_o |-> $past(w1 && wdata_i[GRCB_BIT_PULSE], 2); endproperty
  a_pls: assert property (p_pls) else $error("pulse without cause");
  property p_slip; slip_pulse_o
    |-> $past(w2 && wdata_i[GRCB_BIT_SLIP], 2) ##1 !slip_pulse_o; endproperty
  a_slip: assert property (p_slip) else $error("slip pulse wrong");
  property p_tune; autotune_pulse_o
    |-> $past(w2 && wdata_i[GRCB_BIT_AUTOTUNE], 2); endproperty
  a_tune: assert property (p_tune) else $error("autotune without cause");
endmodule : grcb_chk_sva
`default_nettype wire

// ==== grcb_host.sv ====
// grcb_host: host model on the register port
// strobes change after a rising edge and hold one cycle
`timescale 1ns/10ps
`default_nettype none
module grcb_host
  import grcb_pkg::*;
(
  input wire logic clock_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 16'hFFFF;
    wdata_o = GRCB_ZERO;
  end
  // request bits go back to zero by a later write of zero
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_en_o <= w;
    rd_en_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clock_i);
    wr_en_o <= 1'b0;
    rd_en_o <= 1'b0;
    // released lines invert so a stale value cannot pass
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : xfer
endmodule : grcb_host
`default_nettype wire

// ==== tb.sv ====
// tb: random register traffic checked against an integer model
// loop tick runs every cycle and holdover pin stays low, except in the pin test, which raises the pin on a half-rate tick
`timescale 1ns/10ps
`default_nettype none
module tb
  import grcb_pkg::*;
;
  logic clock_i = 1'b0, rstn_i = 1'b0, wr_en_i, rd_en_i, general_input_pin_i = 1'b0;
  logic loop_tick_i = 1'b1, debounce_bypass_i = 1'b0, reference_loop_holdover_o;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, r;
  logic [3:0] resync_sequencer_state_i = 4'h0;
  logic reseed_pulse_o, pulse_request_o, slip_pulse_o, autotune_pulse_o, soft_reset_o;
  logic high_perf_path_o, mute_drivers_o, sleep_o, restart_o;
  int err_count = 0, n_tests = 0, seed = 53, cyc = 0, n, mdl [3], ex [4], gt [4];
  // pin to agreed request, in clock cycles
  localparam int PIN_SYNC_LAT = 3;
  // loop detector control lives outside this bank, so it reads back as unmapped
  localparam logic [15:0] PUMP_CTRL_OFS = 16'h001B;
  always #2 clock_i = ~clock_i;
  grcb_bank u_dut (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .resync_sequencer_state_i(resync_sequencer_state_i),
    .general_input_pin_i(general_input_pin_i),
    .loop_tick_i(loop_tick_i),
    .debounce_bypass_i(debounce_bypass_i),
    .reseed_pulse_o(reseed_pulse_o),
    .pulse_request_o(pulse_request_o),
    .slip_pulse_o(slip_pulse_o),
    .autotune_pulse_o(autotune_pulse_o),
    .reference_loop_holdover_o(reference_loop_holdover_o),
    .high_perf_path_o(high_perf_path_o),
    .mute_drivers_o(mute_drivers_o),
    .sleep_o(sleep_o),
    .restart_o(restart_o),
    .soft_reset_o(soft_reset_o)
  );
  grcb_host u_host (.clock_i(clock_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    gt[0] <= gt[0] + int'(reseed_pulse_o === 1'b1);
    gt[1] <= gt[1] + int'(pulse_request_o === 1'b1);
    gt[2] <= gt[2] + int'(slip_pulse_o === 1'b1);
    gt[3] <= gt[3] + int'(autotune_pulse_o === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wm(input int a, input logic [7:0] d);
    logic [7:0] nv, up;
    nv = d & (a == 0 ? GRCB_MASK_SOFT_RESET : a == 1 ? GRCB_MASK_REQUEST_MODE : GRCB_MASK_TRIGGER);
    up = nv & ~8'(mdl[a]);
    u_host.xfer(1'b1, 16'(a), d);
    // sequencer state is held through the write, so it is read after
    ex[0] += int'(a == 1 && up[7] && resync_sequencer_state_i == GRCB_SEQ_DONE);
    ex[1] += int'(a == 1 && up[2]);
    ex[2] += int'(a == 2 && up[1]);
    ex[3] += int'(a == 2 && up[2]);
    mdl[a] = nv;
    if (a == 0)
      mdl = '{0, 0, 0};
  endtask : wm
  task automatic rd(input int a, input logic [7:0] e);
    u_host.xfer(1'b0, 16'(a), GRCB_ZERO);
    @(negedge clock_i);
    chk(rdata_o, e);
  endtask : rd
  initial
  begin
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 4; a++) rd(a, GRCB_ZERO);
    u_host.xfer(1'b1, PUMP_CTRL_OFS, GRCB_ZERO);
    rd(int'(PUMP_CTRL_OFS), GRCB_ZERO);
    repeat (60)
    begin
      n = 1 + int'($unsigned($random(seed)) % 2);
      @(posedge clock_i) resync_sequencer_state_i <= $random(seed) & 1 ? GRCB_SEQ_DONE : 4'h5;
      r = 8'($random(seed));
      r[4] = 1'b0;
      wm(n, r);
      repeat (2) @(posedge clock_i);
      rd(n, 8'(mdl[n]));
      chk(8'({high_perf_path_o, mute_drivers_o, sleep_o, restart_o}),
        8'({mdl[1][6], mdl[1][3], mdl[1][0], mdl[1][1]}));
    end
    for (int i = 0; i < 4; i++) chk(8'(gt[i]), 8'(ex[i]));
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clock_i) debounce_bypass_i <= b[0];
      wm(1, 8'h10);
      // the register bit is set at the write edge; count edges from there
      n = 0;
      @(negedge clock_i);
      while (reference_loop_holdover_o !== 1'b1 && n < 20)
      begin
        @(negedge clock_i);
        n++;
      end
      chk(8'(n), 8'(b == 1 ? GRCB_HOLD_LAT_BYP : GRCB_HOLD_LAT_DEB));
      wm(1, GRCB_ZERO);
      repeat (12) @(posedge clock_i);
    end
    // pin request: three sync flops, then the debouncer on a half-rate tick
    @(posedge clock_i)
    begin
      general_input_pin_i <= 1'b1;
      debounce_bypass_i <= 1'b0;
    end
    n = 0;
    while (reference_loop_holdover_o !== 1'b1 && n < 40)
    begin
      @(posedge clock_i) loop_tick_i <= ~loop_tick_i;
      @(negedge clock_i) n++;
    end
    chk(8'(n), 8'(PIN_SYNC_LAT + 2 * GRCB_HOLD_LAT_DEB));
    @(posedge clock_i)
    begin
      general_input_pin_i <= 1'b0;
      loop_tick_i <= 1'b1;
    end
    n = 0;
    while (reference_loop_holdover_o !== 1'b0 && n < 40)
    begin
      @(posedge clock_i);
      @(negedge clock_i) n++;
    end
    chk(8'(n), 8'(PIN_SYNC_LAT + GRCB_HOLD_LAT_DEB));
    wm(1, 8'hC9);
    wm(0, 8'h01);
    repeat (2) @(posedge clock_i);
    for (int a = 0; a < 3; a++) rd(a, 8'(mdl[a]));
    chk(8'({mute_drivers_o, sleep_o, restart_o, soft_reset_o}), GRCB_ZERO);
    conclude();
  end
endmodule : tb
bind grcb_bank grcb_chk_sva u_sva (
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .wr_en_i(wr_en_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .resync_sequencer_state_i(resync_sequencer_state_i),
  .reseed_pulse_o(reseed_pulse_o),
  .pulse_request_o(pulse_request_o),
  .slip_pulse_o(slip_pulse_o),
  .autotune_pulse_o(autotune_pulse_o),
  .mute_drivers_o(mute_drivers_o),
  .sleep_o(sleep_o),
  .soft_reset_o(soft_reset_o)
);
`default_nettype wire
